/* rtl/rx_snap_pkg.sv */
// Constants, register map and carrier types for the receive ICP snapshot bank
package rx_snap_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEL_W = 3;

  // Register byte addresses on the host port
  localparam logic [ADDR_W-1:0] ADDR_LINK_SEL = 9'h117;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_ID = 9'h118;
  localparam logic [ADDR_W-1:0] ADDR_CELL_OFFSET = 9'h119;
  localparam logic [ADDR_W-1:0] ADDR_FRAME_SEQ = 9'h11A;
  localparam logic [ADDR_W-1:0] ADDR_CHANGE_SEQ = 9'h11B;
  localparam logic [ADDR_W-1:0] ADDR_LOSS_COUNT = 9'h11C;
  localparam logic [ADDR_W-1:0] ADDR_IDENTITY = 9'h11D;
  localparam logic [ADDR_W-1:0] ADDR_DELIN_STATE = 9'h11E;

  // Reset values
  localparam logic [DATA_W-1:0] RST_GROUP_ID = 8'h00;
  localparam logic [DATA_W-1:0] RST_CELL_OFFSET = 8'h00;
  localparam logic [DATA_W-1:0] RST_FRAME_SEQ = 8'h01;
  localparam logic [DATA_W-1:0] RST_CHANGE_SEQ = 8'h00;
  localparam logic [DATA_W-1:0] RST_LOSS_COUNT = 8'h00;
  localparam logic [DATA_W-1:0] RST_IDENTITY = 8'h20;
  localparam logic [DATA_W-1:0] RST_DELIN_STATE = 8'h00;
  localparam logic [SEL_W-1:0] RST_LINK_SEL = 3'h0;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // Frame length codes and the cell offset masks they imply
  localparam logic [1:0] FLEN_32 = 2'h0;
  localparam logic [1:0] FLEN_64 = 2'h1;
  localparam logic [1:0] FLEN_128 = 2'h2;
  localparam logic [1:0] FLEN_256 = 2'h3;
  localparam logic [DATA_W-1:0] MASK_32 = 8'h1F;
  localparam logic [DATA_W-1:0] MASK_64 = 8'h3F;
  localparam logic [DATA_W-1:0] MASK_128 = 8'h7F;
  localparam logic [DATA_W-1:0] MASK_256 = 8'hFF;

  // Delineation state encodings
  localparam logic [1:0] DELIN_HUNT = 2'h0;
  localparam logic [1:0] DELIN_PRESYNC = 2'h1;
  localparam logic [1:0] DELIN_SYNC = 2'h2;
  localparam logic [1:0] DELIN_STUFF = 2'h3;

  // Unused top bits of the delineation state register
  localparam logic [1:0] DELIN_PAD = 2'h0;

  // Values captured by the receive path for one link
  typedef struct packed {
    logic [7:0] group_id;
    logic [7:0] cell_offset;
    logic [7:0] frame_seq;
    logic [7:0] change_seq;
    logic [7:0] loss_count;
    logic frame_lost;
    logic cell_lost;
    logic ref_link;
    logic [4:0] link_id;
    logic [1:0] frame_len;
    logic [1:0] frame_state;
    logic [1:0] cell_state;
  } link_icp_s;

  // Host register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] wdata;
  } host_req_s;

endpackage

/* rtl/rx_link_icp_snapshot.sv */
// Receive link ICP snapshot bank behind the 8-bit host register port
// Functional notes
// - Host writes 3-bit link number to select register
// - Select write refreshes all snapshots immediately
// - Group identifier of chosen link, read only
// - Cell offset masked by frame length
// - Frame sequence number of chosen link
// - Change sequence number of chosen link
// - Out-of-frame counter of chosen link
// - Frame loss bit 7, cell loss bit 6
// - Bit 5 set for timing reference link
// - Link identifier in identity bits 4:0
// - Frame length code at state bits 5:4
// - Frame state 3:2, cell state 1:0
// - State register bits 7:6 read zero
`timescale 1ns/10ps
`default_nettype none

module rx_link_icp_snapshot #(
  parameter int unsigned NUM_LINKS = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire rx_snap_pkg::host_req_s host_req,
  input wire rx_snap_pkg::link_icp_s [NUM_LINKS-1:0] link_icp,
  output logic [rx_snap_pkg::DATA_W-1:0] host_rdata,
  output logic [rx_snap_pkg::SEL_W-1:0] link_sel
);

  // Offset mask chosen by frame length code; a short frame has fewer
  // meaningful offset bits and the unused ones must never read as set
  function automatic logic [rx_snap_pkg::DATA_W-1:0] offset_mask(input logic [1:0] flen);
    logic [rx_snap_pkg::DATA_W-1:0] m;
    m = rx_snap_pkg::MASK_256;
    unique case (flen)
      rx_snap_pkg::FLEN_32: m = rx_snap_pkg::MASK_32;
      rx_snap_pkg::FLEN_64: m = rx_snap_pkg::MASK_64;
      rx_snap_pkg::FLEN_128: m = rx_snap_pkg::MASK_128;
      rx_snap_pkg::FLEN_256: m = rx_snap_pkg::MASK_256;
    endcase
    return m;
  endfunction

  // Identity byte: loss flags high, reference flag, then link identifier;
  // the field order matches the identity register bit for bit
  function automatic logic [rx_snap_pkg::DATA_W-1:0] identity_byte(
    input rx_snap_pkg::link_icp_s lane
  );
    return {lane.frame_lost, lane.cell_lost, lane.ref_link, lane.link_id};
  endfunction

  // State byte: zero pad, frame length, frame and cell delineation codes;
  // the codes pass through untouched, including the stuffed-frame code
  function automatic logic [rx_snap_pkg::DATA_W-1:0] delin_byte(
    input rx_snap_pkg::link_icp_s lane
  );
    return {rx_snap_pkg::DELIN_PAD, lane.frame_len, lane.frame_state, lane.cell_state};
  endfunction

  // Select register, the seven snapshots and the read data register;
  // none of the snapshots can be written by the host
  logic [rx_snap_pkg::SEL_W-1:0] sel_q;
  logic [rx_snap_pkg::DATA_W-1:0] group_id_q;
  logic [rx_snap_pkg::DATA_W-1:0] cell_offset_q;
  logic [rx_snap_pkg::DATA_W-1:0] frame_seq_q;
  logic [rx_snap_pkg::DATA_W-1:0] change_seq_q;
  logic [rx_snap_pkg::DATA_W-1:0] loss_count_q;
  logic [rx_snap_pkg::DATA_W-1:0] identity_q;
  logic [rx_snap_pkg::DATA_W-1:0] delin_state_q;
  logic [rx_snap_pkg::DATA_W-1:0] rdata_q;
  logic [rx_snap_pkg::DATA_W-1:0] rdata_d;

  // Per-link register images, one lane per populated link; unpopulated
  // select numbers have no lane and are caught before the lanes are read
  wire logic [NUM_LINKS-1:0][rx_snap_pkg::DATA_W-1:0] lane_offset;
  wire logic [NUM_LINKS-1:0][rx_snap_pkg::DATA_W-1:0] lane_identity;
  wire logic [NUM_LINKS-1:0][rx_snap_pkg::DATA_W-1:0] lane_delin;

  // Host request decode and the values taken from the chosen link
  wire logic sel_write;
  wire logic [rx_snap_pkg::SEL_W-1:0] new_sel;
  wire logic new_sel_valid;
  wire rx_snap_pkg::link_icp_s chosen;
  wire logic [rx_snap_pkg::DATA_W-1:0] sel_readback;
  wire logic [rx_snap_pkg::DATA_W-1:0] group_id_d;
  wire logic [rx_snap_pkg::DATA_W-1:0] cell_offset_d;
  wire logic [rx_snap_pkg::DATA_W-1:0] frame_seq_d;
  wire logic [rx_snap_pkg::DATA_W-1:0] change_seq_d;
  wire logic [rx_snap_pkg::DATA_W-1:0] loss_count_d;
  wire logic [rx_snap_pkg::DATA_W-1:0] identity_d;
  wire logic [rx_snap_pkg::DATA_W-1:0] delin_state_d;

  // Offset, identity and state bytes are built for every link in parallel, so
  // the select write only has to steer finished bytes into the snapshots
  for (genvar g = 0; g < NUM_LINKS; g++)
  begin : g_lane
    assign lane_offset[g] = link_icp[g].cell_offset & offset_mask(link_icp[g].frame_len);
    assign lane_identity[g] = identity_byte(link_icp[g]);
    assign lane_delin[g] = delin_byte(link_icp[g]);
  end
  // Each lane costs three bytes of logic per link; that is traded for a
  // capture path with no decode after the select mux

  assign sel_write = host_req.wr && (host_req.addr == rx_snap_pkg::ADDR_LINK_SEL);
  assign new_sel = host_req.wdata[rx_snap_pkg::SEL_W-1:0];
  // Select numbers are three bits wide but only NUM_LINKS links exist, so
  // the upper numbers are flagged here and steered to zero below
  assign new_sel_valid = (32'(new_sel) < NUM_LINKS);
  // Select readback: the stored link number zero-extended to a full byte
  assign sel_readback = {{(rx_snap_pkg::DATA_W - rx_snap_pkg::SEL_W){1'b0}}, sel_q};

  // Links beyond the populated set capture all-zero fields; the host may still
  // write those numbers, so they must land on a defined value, not stale data
  assign chosen = new_sel_valid ? link_icp[new_sel] : '0;
  // Plain fields come straight from the chosen link
  assign group_id_d = chosen.group_id;
  assign frame_seq_d = chosen.frame_seq;
  assign change_seq_d = chosen.change_seq;
  assign loss_count_d = chosen.loss_count;
  // Assembled bytes come from the chosen lane
  assign cell_offset_d = new_sel_valid ? lane_offset[new_sel] : rx_snap_pkg::READ_ZERO;
  assign identity_d = new_sel_valid ? lane_identity[new_sel] : rx_snap_pkg::READ_ZERO;
  assign delin_state_d = new_sel_valid ? lane_delin[new_sel] : rx_snap_pkg::READ_ZERO;

  // Link select register; only bits 2:0 of the written byte are stored, the
  // rest of the byte is dropped and reads back as zero
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_q <= rx_snap_pkg::RST_LINK_SEL;
    end
    else if (sel_write)
    begin
      sel_q <= new_sel;
    end
  end

  // All seven snapshots load on the same select write edge, never in between,
  // so a host that reads them one by one still sees one moment of one link.
  // Later changes on the links stay invisible until the next select write;
  // rewriting the same link number is how software refreshes the picture.
  // Writes to the snapshot addresses themselves are simply not decoded, so
  // they can never disturb a captured value.
  // refresh on select write
  // single-cycle coherent capture
  // Group identifier snapshot
  // Taken from the last valid control cell of the chosen link
  // group identifier capture
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      group_id_q <= rx_snap_pkg::RST_GROUP_ID;
    end
    else if (sel_write)
    begin
      group_id_q <= group_id_d;
    end
  end

  // Cell offset snapshot, already masked to the frame length
  // Masking at capture keeps the read path a plain byte mux
  // masked offset capture
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cell_offset_q <= rx_snap_pkg::RST_CELL_OFFSET;
    end
    else if (sel_write)
    begin
      cell_offset_q <= cell_offset_d;
    end
  end

  // Frame sequence snapshot
  // Resets to one rather than zero
  // frame sequence capture
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      frame_seq_q <= rx_snap_pkg::RST_FRAME_SEQ;
    end
    else if (sel_write)
    begin
      frame_seq_q <= frame_seq_d;
    end
  end

  // Status and control change sequence snapshot
  // Lets software spot a new control change on the link
  // change sequence capture
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      change_seq_q <= rx_snap_pkg::RST_CHANGE_SEQ;
    end
    else if (sel_write)
    begin
      change_seq_q <= change_seq_d;
    end
  end

  // Out-of-frame event counter snapshot
  // A live counter would tear between reads, so it is frozen here too
  // out-of-frame counter capture
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      loss_count_q <= rx_snap_pkg::RST_LOSS_COUNT;
    end
    else if (sel_write)
    begin
      loss_count_q <= loss_count_d;
    end
  end

  // Link identity snapshot
  // Resets with the reference flag set and both loss flags clear
  // link identity capture
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      identity_q <= rx_snap_pkg::RST_IDENTITY;
    end
    else if (sel_write)
    begin
      identity_q <= identity_d;
    end
  end

  // Delineation state snapshot
  // Frame length and both state machine codes in one byte
  // delineation state capture
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      delin_state_q <= rx_snap_pkg::RST_DELIN_STATE;
    end
    else if (sel_write)
    begin
      delin_state_q <= delin_state_d;
    end
  end

  // Read decode; unmapped addresses return zero. The select register reads
  // back here as well, so software can confirm which link is on show
  always_comb
  begin
    rdata_d = rx_snap_pkg::READ_ZERO;
    unique case (host_req.addr)
      rx_snap_pkg::ADDR_LINK_SEL: rdata_d = sel_readback;
      rx_snap_pkg::ADDR_GROUP_ID: rdata_d = group_id_q;
      rx_snap_pkg::ADDR_CELL_OFFSET: rdata_d = cell_offset_q;
      rx_snap_pkg::ADDR_FRAME_SEQ: rdata_d = frame_seq_q;
      rx_snap_pkg::ADDR_CHANGE_SEQ: rdata_d = change_seq_q;
      rx_snap_pkg::ADDR_LOSS_COUNT: rdata_d = loss_count_q;
      rx_snap_pkg::ADDR_IDENTITY: rdata_d = identity_q;
      rx_snap_pkg::ADDR_DELIN_STATE: rdata_d = delin_state_q;
      default: rdata_d = rx_snap_pkg::READ_ZERO;
    endcase
  end

  // Registered read data, held until the next read. A read in the same cycle
  // as a select write returns the old snapshot, since the decode sees the
  // registers before that edge updates them; software reads one cycle later
  // to see the newly chosen link.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= rx_snap_pkg::READ_ZERO;
    end
    else if (host_req.rd)
    begin
      rdata_q <= rdata_d;
    end
  end

  // Both ports come straight from flip-flops
  assign host_rdata = rdata_q;
  assign link_sel = sel_q;

endmodule // rx_link_icp_snapshot

`default_nettype wire

/* dv/rx_snap_sva.sv */
// Checker for the receive ICP snapshot bank
`timescale 1ns/10ps
`default_nettype none
module rx_snap_sva #(parameter int unsigned NUM_LINKS = 4) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire rx_snap_pkg::host_req_s host_req,
  input wire rx_snap_pkg::link_icp_s [NUM_LINKS-1:0] link_icp,
  input wire logic [7:0] host_rdata,
  input wire logic [2:0] link_sel
);
  // Decoded view of the host request
  wire logic [8:0] a = host_req.addr;
  wire logic r = host_req.rd & ~host_req.wr;
  wire logic ws = host_req.wr & (a == 9'h117);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_sel_load; ws |=> link_sel == $past(host_req.wdata[2:0]); endproperty
  a_sel_load: assert property (p_sel_load) else $error("select not loaded");
  property p_sel_keep; !ws |=> $stable(link_sel); endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("select moved");
  property p_sel_read; r && a == 9'h117 |=> host_rdata == {5'h00, link_sel}; endproperty
  a_sel_read: assert property (p_sel_read) else $error("select readback");
  property p_pad; r && a == 9'h11E |=> host_rdata[7:6] == 2'h0; endproperty
  a_pad: assert property (p_pad) else $error("state pad not zero");
  property p_hold; !host_req.rd |=> $stable(host_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; r && (a < 9'h117 || a > 9'h11E) |=> host_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_mask;
    r && a == 9'h11E ##1 r && a == 9'h119
      |=> (host_rdata & ~(8'hFF >> (2'h3 - $past(host_rdata[5:4])))) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("offset not masked");
  property p_cap;
    ws && host_req.wdata[2:0] == 3'h0 ##1 r && a == 9'h118
      |=> host_rdata == $past(link_icp[0].group_id, 2);
  endproperty
  a_cap: assert property (p_cap) else $error("group id not captured");
endmodule // rx_snap_sva
bind rx_link_icp_snapshot rx_snap_sva #(.NUM_LINKS(NUM_LINKS)) u_sva (.sys_clk(sys_clk),
  .rst(rst), .host_req(host_req), .link_icp(link_icp), .host_rdata(host_rdata),
  .link_sel(link_sel));
`default_nettype wire

/* dv/rx_path_model.sv */
// Receive path stand-in driving live ICP values for four links
`timescale 1ns/10ps
`default_nettype none
module rx_path_model (
  input wire logic sys_clk,
  input wire logic [31:0] rnd,
  output var rx_snap_pkg::link_icp_s [3:0] link_icp
);
  // Spread the random word so every link differs
  wire logic [223:0] fill = {7{rnd}};
  initial link_icp = '0;
  always @(posedge sys_clk)
    link_icp <= fill[215:0];
endmodule // rx_path_model
`default_nettype wire

/* dv/rx_link_icp_snapshot_tb_top.sv */
// Testbench for the receive ICP snapshot bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module rx_link_icp_snapshot_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  rx_snap_pkg::host_req_s host_req = '0;
  rx_snap_pkg::link_icp_s [3:0] link_icp;
  rx_snap_pkg::link_icp_s cur;
  logic [7:0] host_rdata;
  logic [2:0] link_sel;
  logic [2:0] cs = 3'h0;
  logic [31:0] rnd = 32'h4407CCE3;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  initial forever #5 sys_clk = ~sys_clk;
  rx_path_model far (.sys_clk(sys_clk), .rnd(rnd), .link_icp(link_icp));
  rx_link_icp_snapshot #(.NUM_LINKS(4)) uut (.sys_clk(sys_clk), .rst(rst),
    .host_req(host_req), .link_icp(link_icp), .host_rdata(host_rdata), .link_sel(link_sel));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Register contents expected from the last captured link
  function automatic logic [7:0] reg_of(input logic [8:0] a);
    case (a)
      9'h117: reg_of = {5'h00, cs};
      9'h118: reg_of = cur.group_id;
      9'h119: reg_of = cur.cell_offset & (8'hFF >> (2'h3 - cur.frame_len));
      9'h11A: reg_of = cur.frame_seq;
      9'h11B: reg_of = cur.change_seq;
      9'h11C: reg_of = cur.loss_count;
      9'h11D: reg_of = {cur.frame_lost, cur.cell_lost, cur.ref_link, cur.link_id};
      9'h11E: reg_of = {2'h0, cur.frame_len, cur.frame_state, cur.cell_state};
      default: reg_of = 8'h00;
    endcase
  endfunction
  // One host cycle, noting the answer a read should bring
  task automatic op(input logic w, input logic r, input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    host_req = '{a, w, r, d};
    if (r)
      exp_q.push_back(reg_of(a));
    if (w && a == 9'h117)
    begin
      cs = d[2:0];
      cur = d[2] ? '0 : link_icp[d[1:0]];
    end
  endtask
  task automatic read_all();
    op(0, 1, 9'h118, 8'h00);
    op(0, 1, 9'h11E, 8'h00);
    op(0, 1, 9'h119, 8'h00);
    for (int a = 9'h117; a <= 9'h120; a++)
      op(0, 1, a[8:0], 8'h00);
    op(0, 0, 9'h000, 8'h00);
  endtask
  task automatic conclude();
    $display("Compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Take the oldest note whenever a read answer appears
  always @(posedge sys_clk)
    rd_d <= host_req.rd;
  always @(negedge sys_clk)
    if (rd_d)
    begin
      e = exp_q.pop_front();
      `CHK("host_rdata", e, host_rdata)
    end
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      conclude();
    end
  end
  initial
  begin
    cur = '0;
    cur.frame_seq = 8'h01;
    cur.ref_link = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    read_all();
    $display("Test reset values done");
    op(1, 0, 9'h118, 8'hFF);
    op(1, 0, 9'h120, 8'hFF);
    read_all();
    $display("Test ignored writes done");
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      repeat (2) op(0, 0, 9'h000, 8'h00);
      op(1, 0, 9'h117, {rnd[9:5], i[2:0]});
      read_all();
      rnd = lfsr(rnd);
      repeat (2) op(0, 0, 9'h000, 8'h00);
      read_all();
      $display("Test select %0d done", i);
    end
    repeat (2) @(posedge sys_clk);
    conclude();
  end
endmodule // rx_link_icp_snapshot_tb_top
`default_nettype wire
